/* File: rtl/sbsc_control.sv */
// Synchronous burst memory control: decode, burst counter, write and drive
//
// Design decisions made here: the address-and-strobe port and the address map.
`timescale 1ns/1ns
module sbsc_control #(
    parameter int LANES     = 4,
    parameter int ADDR_BITS = 18
) (
    // Clock, reset, enable
    input  wire logic                          clk,
    input  wire logic                          reset_n,
    input  wire logic                          clk_en,
    // Bus controls and mode straps
    input  wire sbsc_pkg::sbsc_ctl_type        ctl,
    input  wire sbsc_pkg::sbsc_mode_type       mode,
    input  wire logic [ADDR_BITS-1:0]          addr_in,
    input  wire logic [LANES-1:0]              byte_en_n,
    input  wire logic                          out_en_n,
    // Array side
    output logic [ADDR_BITS-1:0]               mem_addr,
    output logic                               mem_rd,
    output logic                               mem_wr,
    output logic [LANES-1:0]                   mem_lane_we,
    output logic [LANES-1:0]                   lane_active,
    output logic                               parity_active,
    output logic                               standby,
    output logic                               low_drive,
    // Data pin drive
    output logic                               data_oe_n
);
    typedef struct packed {
        logic [ADDR_BITS-1:0] base;
        logic [1:0]           start;
        logic [1:0]           step;
        logic [ADDR_BITS-1:0] addr;
        logic                 rd;
        logic                 wr;
        logic [LANES-1:0]     lane_we;
        logic [LANES-1:0]     lane_act;
        logic                 par;
        logic                 sby;
        logic                 lowd;
        logic                 drv1;
        logic                 drv2;
        logic                 oe_n;
    } sbsc_state_type;

    sbsc_state_type state_reg;
    sbsc_state_type state_next;
    logic           write_flag;
    logic           enabled;
    logic           deselect;
    logic           load;
    logic           access;
    logic           drive_src;
    logic [1:0]     step_now;

    // Burst address from start and step in the chosen order
    function automatic logic [1:0] burst_addr(input logic [1:0] st,
                                             input logic [1:0] sp,
                                             input logic       inter);
        logic [1:0] r;
        r = inter ? (st ^ sp) : 2'(st + sp);
        return r;
    endfunction

    // Decode of the synchronous controls
    always_comb begin
        write_flag = !ctl.global_write_n || !ctl.byte_write_n;
        enabled = !ctl.chip_en1_n && ctl.chip_en2 && !ctl.chip_en3_n;
        deselect = (ctl.chip_en1_n && !ctl.ctrl_addr_strobe_n) ||
                   (!ctl.chip_en1_n && (!ctl.chip_en2 || ctl.chip_en3_n) &&
                    (!ctl.proc_addr_strobe_n ||
                     !ctl.ctrl_addr_strobe_n));
        load = enabled && (!ctl.proc_addr_strobe_n ||
                           !ctl.ctrl_addr_strobe_n);
        access = load || (ctl.ctrl_addr_strobe_n &&
                 (ctl.proc_addr_strobe_n || ctl.chip_en1_n));
    end

    // Next state of the whole block
    always_comb begin
        state_next = state_reg;
        step_now = state_reg.step;
        state_next.rd = 1'b0;
        state_next.wr = 1'b0;
        state_next.lane_we = '0;
        if (load) begin
            state_next.base = addr_in;
            state_next.start = addr_in[1:0];
            state_next.step = sbsc_pkg::BURST_ZERO;
            step_now = sbsc_pkg::BURST_ZERO;
        end else if (access && !ctl.burst_advance_n) begin
            step_now = 2'(state_reg.step + sbsc_pkg::BURST_ONE);
            state_next.step = step_now;
        end
        // Holding the step repeats the current address
        if (access && !deselect) begin
            state_next.addr = {state_next.base[ADDR_BITS-1:2],
                burst_addr(state_next.start, step_now,
                           mode.burst_order_sel_n)};
            if (write_flag && !(load && !ctl.proc_addr_strobe_n)) begin
                state_next.wr = 1'b1;
                state_next.lane_we = !ctl.global_write_n ? '1 :
                                     ~byte_en_n;
            end else begin
                state_next.rd = 1'b1;
            end
        end
        // Lane c and d exist only in the wide organisation
        state_next.lane_we = state_next.lane_we &
                             ((LANES > 2) ? '1 : LANES'(2'h3));
        state_next.lane_act = (LANES > 2) ? '1 : LANES'(2'h3);
        state_next.par = !mode.parity_lane_en_n;
        state_next.sby = mode.sleep_ctl;
        state_next.lowd = mode.drive_strength_sel;
        // Drive pipeline: dual deselect holds drive one stage longer
        drive_src = state_next.rd && !mode.sleep_ctl;
        state_next.drv1 = drive_src;
        state_next.drv2 = state_reg.drv1;
        if (!mode.flow_through_sel_n) begin
            state_next.oe_n = !(drive_src ||
                (!mode.deselect_mode_sel && state_reg.drv1));
        end else begin
            state_next.oe_n = !(state_reg.drv1 ||
                (!mode.deselect_mode_sel && state_reg.drv2));
        end
        // Writes keep the data pins floating even behind a read
        state_next.oe_n = state_next.oe_n || out_en_n ||
                          state_next.wr;
    end

    // State register
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg <= '0;
            state_reg.oe_n <= 1'b1;
        end else if (clk_en) begin
            state_reg <= state_next;
        end
    end

    // Outputs straight from the register
    always_comb begin
        mem_addr = state_reg.addr;
        mem_rd = state_reg.rd;
        mem_wr = state_reg.wr;
        mem_lane_we = state_reg.lane_we;
        lane_active = state_reg.lane_act;
        parity_active = state_reg.par;
        standby = state_reg.sby;
        low_drive = state_reg.lowd;
        data_oe_n = state_reg.oe_n;
    end

    // Checks, all on the one clock and idle in reset
    default clocking chk_cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    // Load takes the two low address bits as start
    AST_LOAD_START: assert property (
        clk_en && load
        |=> state_reg.start == $past(addr_in[1:0]))
        else $error("start not loaded");

    // Write cycles never drive the data pins
    AST_WRITE_FLOAT: assert property (
        mem_wr
        |-> data_oe_n)
        else $error("data driven during write");

    // Global write hits every existing lane
    AST_GLOBAL_ALL: assert property (
        clk_en && load && !ctl.global_write_n && ctl.proc_addr_strobe_n
        |=> mem_wr && mem_lane_we == lane_active)
        else $error("global write missed lanes");

    // Deselect gives no array access
    AST_DESELECT: assert property (
        clk_en && deselect
        |=> !mem_rd && !mem_wr)
        else $error("access during deselect");

    // Processor strobe on an enabled chip starts a read
    AST_PROC_READ: assert property (
        clk_en && enabled && !ctl.proc_addr_strobe_n
        |=> mem_rd)
        else $error("processor strobe not a read");

    // Advance steps the counter by one, modulo four
    AST_ADVANCE: assert property (
        clk_en && access && !load && !ctl.burst_advance_n
        |=> state_reg.step == 2'($past(state_reg.step) + 2'h1))
        else $error("advance missed");

    // Advance high holds the counter
    AST_HOLD: assert property (
        clk_en && !load && ctl.burst_advance_n
        |=> $stable(state_reg.step))
        else $error("hold moved counter");

    // Output enable high keeps the pins off
    AST_OE_OFF: assert property (
        clk_en && out_en_n
        |=> data_oe_n)
        else $error("drive with output enable high");

    // Parity lanes follow their enable
    AST_PARITY: assert property (
        clk_en
        |=> parity_active == !$past(mode.parity_lane_en_n))
        else $error("parity lane state wrong");

    // Standby follows sleep control
    AST_SLEEP: assert property (
        clk_en
        |=> standby == $past(mode.sleep_ctl))
        else $error("standby wrong");

    // Byte write hits exactly the enabled lanes
    AST_BYTE_LANES: assert property (
        clk_en && load && ctl.proc_addr_strobe_n &&
        ctl.global_write_n && !ctl.byte_write_n
        |=> mem_wr && mem_lane_we == ($past(~byte_en_n) & lane_active))
        else $error("byte write lanes wrong");

    // Both write inputs high make a read
    AST_READ_CYCLE: assert property (
        clk_en && access && !deselect &&
        ctl.global_write_n && ctl.byte_write_n
        |=> mem_rd && !mem_wr)
        else $error("read cycle not a read");

    // Never read and write at once
    AST_RD_WR_EXCL: assert property (
        !(mem_rd && mem_wr))
        else $error("read and write together");

    // Lane write enables only in write cycles
    AST_WE_ONLY_WRITE: assert property (
        mem_lane_we != '0
        |-> mem_wr)
        else $error("lane enable outside write");

    // Controller strobe load with write flag writes
    AST_CTRL_WRITE: assert property (
        clk_en && load && ctl.proc_addr_strobe_n && write_flag
        |=> mem_wr)
        else $error("controller write missed");

    // Controller strobe load without write flag reads
    AST_CTRL_READ: assert property (
        clk_en && load && ctl.proc_addr_strobe_n && !write_flag
        |=> mem_rd)
        else $error("controller read missed");

    // Processor strobe ignores the write inputs
    AST_PROC_NO_WRITE: assert property (
        clk_en && enabled && !ctl.proc_addr_strobe_n
        |=> !mem_wr)
        else $error("processor strobe wrote");

    // Load presents the external address unchanged
    AST_LOAD_ADDR: assert property (
        clk_en && load
        |=> mem_addr == $past(addr_in))
        else $error("load address wrong");

    // Load restarts the counter
    AST_LOAD_STEP: assert property (
        clk_en && load
        |=> state_reg.step == sbsc_pkg::BURST_ZERO)
        else $error("load did not clear step");

    // Linear order adds the step to the start
    AST_LINEAR: assert property (
        clk_en && access && !load && !deselect && !mode.burst_order_sel_n
        |=> mem_addr[1:0] == 2'(state_reg.start + state_reg.step))
        else $error("linear order wrong");

    // Interleaved order mixes the step into the start
    AST_INTERLEAVE: assert property (
        clk_en && access && !load && !deselect && mode.burst_order_sel_n
        |=> mem_addr[1:0] == (state_reg.start ^ state_reg.step))
        else $error("interleaved order wrong");

    // Continue cycles keep the loaded upper address
    AST_UPPER_KEEP: assert property (
        clk_en && access && !load && !deselect
        |=> mem_addr[ADDR_BITS-1:2] == state_reg.base[ADDR_BITS-1:2])
        else $error("upper address moved");

    // Single deselect turns drive off one cycle after capture
    AST_SCD_OFF: assert property (
        clk_en && deselect && mode.deselect_mode_sel &&
        mode.flow_through_sel_n ##1
        clk_en && mode.deselect_mode_sel && mode.flow_through_sel_n
        |=> data_oe_n)
        else $error("single deselect still driving");

    // Flow-through read drives with its own pulse
    AST_FT_DRIVE: assert property (
        clk_en && !mode.flow_through_sel_n && !out_en_n && !mode.sleep_ctl
        |=> mem_rd |-> !data_oe_n)
        else $error("flow-through read not driven");

    // Pipelined read drives one clock after its pulse
    AST_PIPE_DRIVE: assert property (
        clk_en && state_reg.drv1 && mode.flow_through_sel_n &&
        !out_en_n && !write_flag
        |=> !data_oe_n)
        else $error("pipelined read not driven");

    // No write enable on lanes that do not exist
    AST_LANE_MASK: assert property (
        (mem_lane_we & ~lane_active) == '0)
        else $error("write on missing lane");

    // Lane count matches the organisation
    AST_LANE_COUNT: assert property (
        clk_en
        |=> $countones(lane_active) == ((LANES > 2) ? LANES : 2))
        else $error("lane count wrong");

    // Drive strength follows its select
    AST_DRIVE_SEL: assert property (
        clk_en
        |=> low_drive == $past(mode.drive_strength_sel))
        else $error("drive strength wrong");

    // Clock enable low freezes all state
    AST_FROZEN: assert property (
        !clk_en
        |=> $stable(state_reg))
        else $error("state moved while frozen");

    // Standby never starts a drive
    AST_SLEEP_NO_DRIVE: assert property (
        clk_en && mode.sleep_ctl
        |=> !state_reg.drv1)
        else $error("drive started in standby");

    // Main scenarios
    COV_READ: cover property (mem_rd ##1 !data_oe_n);
    COV_WRITE: cover property (mem_wr);
    COV_BURST: cover property (state_reg.step == 2'h3);
    COV_DESEL: cover property (clk_en && deselect);
    COV_FLOW: cover property (!mode.flow_through_sel_n && mem_rd);
endmodule

/* File: rtl/sbsc_pkg.sv */
// Package: constants, modes and carriers for the burst memory control logic
// Contract
// - Order select low: linear upward burst modulo four
// - Order select high: start XOR step, wraps fifth
// - Deselect mode low dual, high single cycle
// - Unconnected defaults: pipelined, single deselect, active, parity
// - Sleep low active, sleep high standby power-down
// - Parity enable low uses ninth bits, high disables
// - Global write all bytes, byte write enabled lanes
// - Write flag true on global or byte write
// - Reads drive all lanes, writes float data
// - Lanes c and d only in wide organisation
// - Deselect, power down, float on disabled strobe cases
// - Enabled with processor strobe: load, read burst
// - Enabled controller strobe: load, burst by write flag
// - Strobes high, advance low: next burst address
// - Strobes high, advance high: hold, repeat access
// - Output enable high disables drivers, low gates reads
// - Two low address bits preset the counter
// - Dummy read advances counter like normal read
package sbsc_pkg;
    localparam int LANE_BITS = 9;
    localparam logic [1:0] BURST_ZERO = 2'h0;
    localparam logic [1:0] BURST_ONE  = 2'h1;
    typedef enum logic [1:0] {SBSC_IDLE, SBSC_READ, SBSC_WRITE} sbsc_op_type;
    typedef struct packed {
        logic chip_en1_n;
        logic chip_en2;
        logic chip_en3_n;
        logic proc_addr_strobe_n;
        logic ctrl_addr_strobe_n;
        logic burst_advance_n;
        logic global_write_n;
        logic byte_write_n;
    } sbsc_ctl_type;
    typedef struct packed {
        logic burst_order_sel_n;
        logic flow_through_sel_n;
        logic sleep_ctl;
        logic deselect_mode_sel;
        logic drive_strength_sel;
        logic parity_lane_en_n;
    } sbsc_mode_type;
endpackage

/* File: dv/sbsc_host_model.sv */
// Bus controller model driving the burst memory control inputs
`timescale 1ns/1ns
module sbsc_host_model (
    // Clock
    input  wire logic              clk,
    // Bus drive
    output sbsc_pkg::sbsc_ctl_type ctl,
    output logic [17:0]            addr_in,
    output logic [3:0]             byte_en_n
);
    // Reset-time levels, no strobe active
    initial begin
        ctl = 8'hBF;
        addr_in = 18'h00000;
        byte_en_n = 4'hF;
    end
    // One bus cycle, launched just after a rising edge
    task automatic put(input logic [7:0] c, input logic [17:0] a,
                       input logic [3:0] be);
        @(posedge clk);
        ctl <= c;
        addr_in <= a;
        byte_en_n <= be;
    endtask
endmodule

/* File: dv/tb_top.sv */
// Self-checking bench for the burst memory control block
`timescale 1ns/1ns
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin errors++; \
$display("FAIL t=%0t got=%0h exp=%0h", $time, g, e); end end
module tb_top;
    logic                    clk = 1'b0;
    logic                    reset_n = 1'b0;
    logic                    out_en_n = 1'b0;
    logic                    clk_en = 1'b1;
    sbsc_pkg::sbsc_mode_type mode = 6'h16;
    sbsc_pkg::sbsc_ctl_type  ctl;
    logic [17:0]             addr_in;
    logic [17:0]             mem_addr;
    logic [3:0]              byte_en_n;
    logic [3:0]              mem_lane_we;
    logic [3:0]              lane_active;
    logic                    mem_rd, mem_wr, parity_active;
    logic                    standby, low_drive, data_oe_n;
    int                      errors = 0;
    int                      checks_done = 0;
    logic                    p_acc = 1'b0;
    logic [1:0]              p_rw, p_lo;
    logic [3:0]              p_we;
    localparam logic [17:0]  BASE = 18'h15A5C;
    // 250 MHz clock
    always #2 clk = ~clk;
    sbsc_host_model host (.clk(clk), .ctl(ctl), .addr_in(addr_in),
                          .byte_en_n(byte_en_n));
    sbsc_control dut (.clk(clk), .reset_n(reset_n), .clk_en(clk_en),
        .ctl(ctl), .mode(mode), .addr_in(addr_in), .byte_en_n(byte_en_n),
        .out_en_n(out_en_n), .mem_addr(mem_addr), .mem_rd(mem_rd),
        .mem_wr(mem_wr), .mem_lane_we(mem_lane_we),
        .lane_active(lane_active), .parity_active(parity_active),
        .standby(standby), .low_drive(low_drive), .data_oe_n(data_oe_n));
    // Launch a cycle, then check the one before it
    task automatic run(input logic [7:0] c, input logic [1:0] a,
                       input logic [3:0] be, input logic [1:0] rw,
                       input logic [1:0] lo, input logic [3:0] we);
        host.put(c, {BASE[17:2], a}, be);
        #1;
        if (p_acc) begin
            `CHK({mem_rd, mem_wr}, p_rw)
            if (p_rw == 2'h1 || out_en_n)
                `CHK(data_oe_n, 1'b1)
            if (p_rw != 2'h0) begin
                `CHK(mem_addr, {BASE[17:2], p_lo})
                `CHK(mem_lane_we, p_we)
            end
        end
        p_acc = 1'b1;
        p_rw = rw;
        p_lo = lo;
        p_we = we;
    endtask
    // Verdict and end of run
    task automatic wrap_up;
        $display("errors=%0d checks=%0d", errors, checks_done);
        if (errors == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Main sequence
    initial begin
        repeat (6) @(posedge clk);
        `CHK({mem_rd, mem_wr, data_oe_n}, 3'h1)
        reset_n <= 1'b1;
        run(8'h55, 2'h1, 4'hF, 2'h1, 2'h1, 4'hF);
        for (int i = 2; i < 6; i++)
            run(8'h59, ~2'(i), 4'h0, 2'h1, 2'(i), 4'hF);
        run(8'h5D, 2'h2, 4'h0, 2'h1, 2'h1, 4'hF);
        run(8'h56, 2'h2, 4'hA, 2'h1, 2'h2, 4'h5);
        run(8'h97, 2'h0, 4'hF, 2'h0, 2'h0, 4'h0);
        out_en_n <= 1'b1;
        mode.burst_order_sel_n <= 1'b1;
        run(8'h07, 2'h0, 4'hF, 2'h0, 2'h0, 4'h0);
        run(8'h4C, 2'h1, 4'h0, 2'h2, 2'h1, 4'h0);
        for (int i = 1; i < 5; i++)
            run(8'h5B, 2'(i), 4'h0, 2'h2, 2'h1 ^ 2'(i), 4'h0);
        run(8'h97, 2'h0, 4'hF, 2'h0, 2'h0, 4'h0);
        out_en_n <= 1'b0;
        mode <= 6'h12;
        run(8'h57, 2'h3, 4'h0, 2'h2, 2'h3, 4'h0);
        run(8'h97, 2'h0, 4'hF, 2'h0, 2'h0, 4'h0);
        @(posedge clk);
        #1 `CHK(data_oe_n, 1'b0)
        @(posedge clk);
        #1 `CHK(data_oe_n, 1'b0)
        @(posedge clk);
        #1 `CHK(data_oe_n, 1'b1)
        mode <= 6'h06;
        run(8'h57, 2'h0, 4'h0, 2'h2, 2'h0, 4'h0);
        run(8'h97, 2'h0, 4'hF, 2'h0, 2'h0, 4'h0);
        `CHK(data_oe_n, 1'b0)
        clk_en <= 1'b0;
        mode <= 6'h3F;
        repeat (2) @(posedge clk);
        #1 `CHK(standby, 1'b0)
        clk_en <= 1'b1;
        repeat (2) @(posedge clk);
        #1 `CHK({standby, parity_active, low_drive}, 3'h5)
        @(posedge clk);
        mode <= 6'h14;
        repeat (2) @(posedge clk);
        #1 `CHK({standby, parity_active, low_drive}, 3'h2)
        @(posedge clk);
        mode <= 6'h16;
        repeat (2) @(posedge clk);
        #1 `CHK({standby, parity_active, low_drive}, 3'h3)
        wrap_up();
    end
    // Watchdog against a hang
    initial begin
        #2000;
        errors++;
        wrap_up();
    end
endmodule
